// ===== logic/hss_pkg.sv
package hss_pkg;
	// ==========================================
	// Transceiver select codes {bit1, bit0}
	localparam logic [1:0] XSEL_RX_ONLY = 2'h0;
	localparam logic [1:0] XSEL_BOTH_ON = 2'h2;
	localparam logic [1:0] XSEL_TX_ONLY = 2'h1;
	localparam logic [1:0] XSEL_BOTH_OFF = 2'h3;

	// ==========================================
	// Timing, in own units and in 100 MHz cycles
	localparam int CLK_MHZ = 100;
	localparam int STARTUP_MS = 2000;
	localparam int STRAP_MS = 500;
	localparam int STARTUP_CYC = STARTUP_MS * 1000 * CLK_MHZ;
	localparam int STRAP_CYC = STRAP_MS * 1000 * CLK_MHZ;
	localparam int FLASH_US = 20;
	localparam int FLASH_CYC = FLASH_US * CLK_MHZ;
	localparam int FILTER_MS = 5;
	localparam int FILTER_CYC = FILTER_MS * 1000 * CLK_MHZ;

	// ==========================================
	// Reset values of pin drivers
	localparam logic LED_OFF = 1'b1;
	localparam logic STRAP_IDLE = 1'b1;

	// Restore request kinds
	typedef enum logic [1:0]
	{
		RESTORE_NONE,
		RESTORE_SERIAL,
		RESTORE_FACTORY
	} restore_e;
endpackage : hss_pkg

// ===== logic/hss_if.sv
interface hss_if;
	// Module pins, seen from the module side
	logic cts;        // Module may send (driven by host)
	logic rts;        // Host may send (driven by module)
	logic dsr;        // Connect request from host
	logic dtr;        // Module ready
	logic link_led_n; // Link indicator, active low
	logic xcvr_sel_bit0;
	logic xcvr_sel_bit1;
	logic green_o_mod;  // Green/strap pin, module side
	logic green_oe_mod;
	logic green_o_host;
	logic green_oe_host;
	logic green_lvl;    // Resolved level incl. pull-up
	logic connect_sw_n; // Connect switch, active low
	logic red_strap_n;  // Aux red pin level, host side

	// Pull-up: undriven reads high, host low wins
	assign green_lvl = (green_oe_host && !green_o_host) ? 1'b0 :
		(green_oe_mod ? green_o_mod : 1'b1);

	modport module_end
	(
		input cts, dsr, green_lvl, connect_sw_n, red_strap_n,
		output rts, dtr, link_led_n, xcvr_sel_bit0, xcvr_sel_bit1,
		output green_o_mod, green_oe_mod
	);
	modport host_end
	(
		output cts, dsr, connect_sw_n, red_strap_n,
		output green_o_host, green_oe_host,
		input rts, dtr, link_led_n, xcvr_sel_bit0, xcvr_sel_bit1,
		input green_lvl
	);
endinterface : hss_if

// ===== logic/hss_host.sv
module hss_host
	import hss_pkg::*;
#(
	parameter int FILTER_CYCLES = FILTER_CYC,
	parameter int HOLD_CYCLES = STRAP_CYC
)
(
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	input wire logic CE_I,
	hss_if.host_end PINS,
	input wire logic HOST_RX_READY_I,
	input wire logic CONNECT_REQ_I,
	input wire logic RESTORE_REQ_I,
	input wire logic CONNECT_SW_I,
	output logic MODULE_MAY_SEND_O,
	output logic MODULE_READY_O,
	output logic LINKED_O,
	output logic XCVR_TX_EN_O,
	output logic XCVR_RX_EN_N_O,
	output logic MODULE_IDLE_O
);
	import hss_pkg::*;

	if (FILTER_CYCLES < 1 || HOLD_CYCLES < 1)
	begin : g_bad_counts
		$error("hss_host: counts must be positive");
	end

	// ==========================================
	// State
	typedef struct packed {
		logic [1:0] rts_s;
		logic [1:0] dtr_s;
		logic [1:0] led_s;
		logic [1:0] sel0_s;
		logic [1:0] sel1_s;
		logic [31:0] filt_cnt;
		logic [31:0] hold_cnt;
		logic linked;
		logic cts;
		logic dsr;
		logic sw_n;
		logic strap_oe;
		logic may_send;
		logic ready;
		logic tx_en;
		logic rx_en_n;
	} state_s;

	state_s cur_ff;
	state_s nxt_ff;

	// Next state
	always_comb
	begin
		nxt_ff = cur_ff;
		nxt_ff.rts_s = {cur_ff.rts_s[0], PINS.rts};
		nxt_ff.dtr_s = {cur_ff.dtr_s[0], PINS.dtr};
		nxt_ff.led_s = {cur_ff.led_s[0], PINS.link_led_n};
		nxt_ff.sel0_s = {cur_ff.sel0_s[0], PINS.xcvr_sel_bit0};
		nxt_ff.sel1_s = {cur_ff.sel1_s[0], PINS.xcvr_sel_bit1};
		// Permission to module follows our receive room
		nxt_ff.cts = HOST_RX_READY_I;
		// Module asks us to pause when it drops its line
		nxt_ff.may_send = cur_ff.rts_s[1];
		nxt_ff.ready = cur_ff.dtr_s[1];
		nxt_ff.dsr = CONNECT_REQ_I;
		nxt_ff.sw_n = !CONNECT_SW_I;
		// Decode select; tx active high, rx active low
		unique case ({cur_ff.sel1_s[1], cur_ff.sel0_s[1]})
			XSEL_RX_ONLY:
			begin
				nxt_ff.tx_en = 1'b0;
				nxt_ff.rx_en_n = 1'b0;
			end
			XSEL_BOTH_ON:
			begin
				nxt_ff.tx_en = 1'b1;
				nxt_ff.rx_en_n = 1'b0;
			end
			XSEL_TX_ONLY:
			begin
				nxt_ff.tx_en = 1'b1;
				nxt_ff.rx_en_n = 1'b1;
			end
			XSEL_BOTH_OFF:
			begin
				nxt_ff.tx_en = 1'b0;
				nxt_ff.rx_en_n = 1'b1;
			end
		endcase
		// Linked follows only a steady level, so flashes pass
		if (!cur_ff.led_s[1] == cur_ff.linked)
			nxt_ff.filt_cnt = '0;
		else if (cur_ff.filt_cnt >= 32'(FILTER_CYCLES - 1))
		begin
			nxt_ff.filt_cnt = '0;
			nxt_ff.linked = !cur_ff.led_s[1];
		end
		else
			nxt_ff.filt_cnt = cur_ff.filt_cnt + 32'h0000_0001;
		// Restore choice latched at the first enabled edge
		if (cur_ff.hold_cnt == '0)
			nxt_ff.strap_oe = RESTORE_REQ_I;
		// Strap held stable through the sampling window
		if (cur_ff.hold_cnt < 32'(HOLD_CYCLES))
			nxt_ff.hold_cnt = cur_ff.hold_cnt + 32'h0000_0001;
		else
			nxt_ff.strap_oe = 1'b0;
	end

	// Register
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			cur_ff <= '0;
			cur_ff.sw_n <= STRAP_IDLE;
			cur_ff.rx_en_n <= 1'b1;
			cur_ff.led_s <= {LED_OFF, LED_OFF};
		end
		else if (CE_I)
		begin
			cur_ff <= nxt_ff;
		end
	end

	// Pin and output drive; aux red strap never pulled low
	assign PINS.cts = cur_ff.cts;
	assign PINS.dsr = cur_ff.dsr;
	assign PINS.connect_sw_n = cur_ff.sw_n;
	assign PINS.red_strap_n = 1'b1;
	assign PINS.green_o_host = 1'b0;
	assign PINS.green_oe_host = cur_ff.strap_oe;
	assign MODULE_MAY_SEND_O = cur_ff.may_send;
	assign MODULE_READY_O = cur_ff.ready;
	assign LINKED_O = cur_ff.linked;
	assign XCVR_TX_EN_O = cur_ff.tx_en;
	assign XCVR_RX_EN_N_O = cur_ff.rx_en_n;
	assign MODULE_IDLE_O = !cur_ff.strap_oe;
endmodule : hss_host

// ===== logic/hss_module.sv
module hss_module
	import hss_pkg::*;
#(
	parameter int STARTUP_CYCLES = STARTUP_CYC,
	parameter int STRAP_CYCLES = STRAP_CYC,
	parameter int FLASH_CYCLES = FLASH_CYC
)
(
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	input wire logic CE_I,
	hss_if.module_end PINS,
	input wire logic [1:0] XCVR_MODE_I,
	input wire logic FLOW_CTRL_EN_I,
	input wire logic RX_SPACE_I,
	input wire logic TX_PENDING_I,
	input wire logic LINK_UP_I,
	input wire logic TRAFFIC_I,
	input wire logic GREEN_ON_I,
	output logic TX_ALLOWED_O,
	output logic CONNECT_REQ_O,
	output logic RUNNING_O,
	output hss_pkg::restore_e RESTORE_O,
	output logic RESTORE_VALID_O
);
	import hss_pkg::*;

	if (STRAP_CYCLES < 1 || STARTUP_CYCLES <= STRAP_CYCLES
		|| FLASH_CYCLES < 1)
	begin : g_bad_timing
		$error("hss_module: bad timing counts");
	end

	typedef enum logic [1:0]
	{
		ST_SAMPLE,
		ST_BOOT,
		ST_RUN
	} phase_e;

	// ==========================================
	// State
	typedef struct packed {
		phase_e phase;
		logic [31:0] cnt;
		logic [31:0] flash_cnt;
		logic [1:0] cts_s;
		logic [1:0] dsr_s;
		logic [1:0] grn_s;
		logic [1:0] sw_s;
		logic dsr_d;
		logic sw_d;
		logic rts;
		logic dtr;
		logic led_n;
		logic sel0;
		logic sel1;
		logic grn_o;
		logic grn_oe;
		logic tx_ok;
		logic conn;
		logic rvalid;
		restore_e restore;
	} state_s;

	state_s cur_ff;
	state_s nxt_ff;

	// ==========================================
	// Decodes shared by the next-state terms
	logic in_run;
	logic dsr_rise;
	logic sw_fall;

	assign in_run = (cur_ff.phase == ST_RUN);
	// Delayed copies track in every phase, so a level held through
	// startup gives no edge once running
	assign dsr_rise = cur_ff.dsr_s[1] && !cur_ff.dsr_d;
	assign sw_fall = !cur_ff.sw_s[1] && cur_ff.sw_d;

	// ==========================================
	// Next state
	// One copy of the state is filled here; the flops take it whole
	always_comb
	begin
		nxt_ff = cur_ff;
		// Pin synchronisers; only the second stage is read below
		nxt_ff.cts_s = {cur_ff.cts_s[0], PINS.cts};
		nxt_ff.dsr_s = {cur_ff.dsr_s[0], PINS.dsr};
		nxt_ff.grn_s = {cur_ff.grn_s[0], PINS.green_lvl};
		nxt_ff.sw_s = {cur_ff.sw_s[0], PINS.connect_sw_n};
		nxt_ff.dsr_d = cur_ff.dsr_s[1];
		nxt_ff.sw_d = cur_ff.sw_s[1];
		nxt_ff.conn = 1'b0;

		// Select pins follow configured mode
		// Mode bit 0 drives select bit 0, mode bit 1 select bit 1
		nxt_ff.sel0 = XCVR_MODE_I[0];
		nxt_ff.sel1 = XCVR_MODE_I[1];
		unique case (cur_ff.phase)
			ST_SAMPLE:
			begin
				// Pin is input only; pull-up reads high
				nxt_ff.grn_oe = 1'b0;
				nxt_ff.cnt = cur_ff.cnt + 32'h0000_0001;
				if (cur_ff.cnt >= 32'(STRAP_CYCLES - 1))
				begin
					nxt_ff.phase = ST_BOOT;
					nxt_ff.rvalid = 1'b1;
					// Synced levels at window end; early bounce ignored
					// Both low: factory; strap low: serial
					if (!cur_ff.grn_s[1] && !cur_ff.sw_s[1])
						nxt_ff.restore = RESTORE_FACTORY;
					else if (!cur_ff.grn_s[1])
						nxt_ff.restore = RESTORE_SERIAL;
					else
						nxt_ff.restore = RESTORE_NONE;
				end
			end
			ST_BOOT:
			begin
				// Counter runs on from the strap window, timed from release
				nxt_ff.cnt = cur_ff.cnt + 32'h0000_0001;
				if (cur_ff.cnt >= 32'(STARTUP_CYCLES - 1))
					nxt_ff.phase = ST_RUN;
			end
			ST_RUN:
			begin
				// Green driven only once startup is done
				nxt_ff.grn_oe = 1'b1;
				nxt_ff.grn_o = GREEN_ON_I;
				// Edge on DSR or switch asks for a connect
				nxt_ff.conn = dsr_rise || sw_fall;
			end
		endcase

		// Handshake lines
		// Ready only while running
		nxt_ff.dtr = in_run && RX_SPACE_I;
		// Host may send only while we have room
		nxt_ff.rts = nxt_ff.dtr;
		// Pause own sending when host drops CTS
		// Flow control off leaves the host line unread
		nxt_ff.tx_ok = in_run && TX_PENDING_I
			&& (cur_ff.cts_s[1] || !FLOW_CTRL_EN_I);

		// Link indicator
		// Link lit while connected, brief blink on traffic
		// Traffic during a blink is not queued: a burst no longer than the blink gives one blink
		if (TRAFFIC_I && cur_ff.flash_cnt == '0)
			nxt_ff.flash_cnt = 32'(FLASH_CYCLES);
		else if (cur_ff.flash_cnt != '0)
			nxt_ff.flash_cnt = cur_ff.flash_cnt - 32'h0000_0001;
		// Active low: high is unlit
		nxt_ff.led_n = !(LINK_UP_I && in_run)
			|| (cur_ff.flash_cnt != '0);
	end

	// ==========================================
	// Register
	// Clock enable low holds every field, counters included
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			cur_ff <= '0;
			cur_ff.phase <= ST_SAMPLE;
			cur_ff.led_n <= LED_OFF;
			cur_ff.sel0 <= XSEL_BOTH_OFF[0];
			cur_ff.sel1 <= XSEL_BOTH_OFF[1];
			cur_ff.grn_s <= {STRAP_IDLE, STRAP_IDLE};
			cur_ff.sw_s <= {STRAP_IDLE, STRAP_IDLE};
			cur_ff.sw_d <= STRAP_IDLE;
			cur_ff.restore <= RESTORE_NONE;
		end
		else if (CE_I)
			cur_ff <= nxt_ff;
	end

	// ==========================================
	// Outputs straight from state
	assign PINS.rts = cur_ff.rts;
	assign PINS.dtr = cur_ff.dtr;
	assign PINS.link_led_n = cur_ff.led_n;
	assign PINS.xcvr_sel_bit0 = cur_ff.sel0;
	assign PINS.xcvr_sel_bit1 = cur_ff.sel1;
	assign PINS.green_o_mod = cur_ff.grn_o;
	assign PINS.green_oe_mod = cur_ff.grn_oe;
	assign TX_ALLOWED_O = cur_ff.tx_ok;
	assign CONNECT_REQ_O = cur_ff.conn;
	assign RUNNING_O = cur_ff.dtr;
	assign RESTORE_O = cur_ff.restore;
	assign RESTORE_VALID_O = cur_ff.rvalid;
endmodule : hss_module

// ===== sim/hss_assertions.sv
module hss_assertions
#(
	parameter int STARTUP_CYCLES = 200
)
(
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	input wire logic dtr,
	input wire logic rts,
	input wire logic link_led_n,
	input wire logic xcvr_sel_bit0,
	input wire logic xcvr_sel_bit1,
	input wire logic green_oe_mod
);
	int cyc_ff;

	// ==========================================
	// Cycle count since reset release
	// Saturates just past startup, so it cannot wrap in long runs
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			cyc_ff <= 0;
		else if (cyc_ff < STARTUP_CYCLES + 8)
			cyc_ff <= cyc_ff + 1;
	end

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RSTN_I);

	// ==========================================
	// Pin behaviour
	sequence idle_pins;
		link_led_n && xcvr_sel_bit0 && xcvr_sel_bit1 && !green_oe_mod && !dtr;
	endsequence
	sequence green_up;
		##[0:4] green_oe_mod;
	endsequence

	AST_RELEASE_IDLE: assert property ($rose(RSTN_I) |-> idle_pins)
		else $error("pins not idle after reset");
	AST_GREEN_EARLY: assert property (cyc_ff < STARTUP_CYCLES |-> !green_oe_mod)
		else $error("green driven before startup end");
	AST_GREEN_ON_TIME: assert property (cyc_ff == STARTUP_CYCLES |-> green_up)
		else $error("green not driven after startup");
	AST_GREEN_HOLDS: assert property ($rose(green_oe_mod) |=> green_oe_mod[*8])
		else $error("green drive dropped in run");
	AST_DTR_EARLY: assert property (cyc_ff < STARTUP_CYCLES |-> !dtr)
		else $error("ready shown before startup end");
	AST_DTR_WITH_GREEN: assert property (dtr |-> green_oe_mod)
		else $error("ready shown outside run");
	AST_RTS_EARLY: assert property (cyc_ff < STARTUP_CYCLES |-> !rts)
		else $error("host let send before startup end");
	AST_LED_DARK_EARLY: assert property (cyc_ff < STARTUP_CYCLES |-> link_led_n)
		else $error("link lit before startup end");
endmodule : hss_assertions

// ===== sim/host_serial_status_strap_interface_tb.sv
module host_serial_status_strap_interface_tb
	import hss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SU = 200;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [1:0] mode = 2'h3;
	logic flow = 1'b0;
	logic lnk = 1'b0;
	logic trf = 1'b0;
	logic hrdy = 1'b0;
	logic creq = 1'b0;
	logic rreq = 1'b0;
	logic csw = 1'b0;
	logic ce = 1'b1;
	logic rxs = 1'b1;
	logic txp = 1'b1;
	logic gon = 1'b1;
	logic allowed, conn_o, running, rvalid, ready, linked, tx_en, rx_en_n;
	logic mays, idle;
	logic [1:0] sel;
	restore_e rst_o;
	int error_cnt = 0;
	int tests_run = 0;
	int npulse, ndark;
	// Rows: mode, flow enable, host ready, tx en, rx en_n, tx allowed
	logic [6:0] rows[4] = '{7'h10, 7'h3f, 7'h45, 7'h6b};
	logic [1:0] st[3] = '{2'h2, 2'h3, 2'h1};
	restore_e ex[3] = '{RESTORE_SERIAL, RESTORE_FACTORY, RESTORE_NONE};

	// ==========================================
	// Both ends and the checker
	hss_if u_hss_if();
	hss_module #(.STARTUP_CYCLES(SU), .STRAP_CYCLES(50), .FLASH_CYCLES(5))
	u_hss_module (.SYS_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce),
		.PINS(u_hss_if), .XCVR_MODE_I(mode), .FLOW_CTRL_EN_I(flow),
		.RX_SPACE_I(rxs), .TX_PENDING_I(txp), .LINK_UP_I(lnk),
		.TRAFFIC_I(trf), .GREEN_ON_I(gon), .TX_ALLOWED_O(allowed),
		.CONNECT_REQ_O(conn_o), .RUNNING_O(running), .RESTORE_O(rst_o),
		.RESTORE_VALID_O(rvalid));
	hss_host #(.FILTER_CYCLES(20), .HOLD_CYCLES(60))
	u_hss_host (.SYS_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce),
		.PINS(u_hss_if), .HOST_RX_READY_I(hrdy), .CONNECT_REQ_I(creq),
		.RESTORE_REQ_I(rreq), .CONNECT_SW_I(csw), .MODULE_MAY_SEND_O(mays),
		.MODULE_READY_O(ready), .LINKED_O(linked), .XCVR_TX_EN_O(tx_en),
		.XCVR_RX_EN_N_O(rx_en_n), .MODULE_IDLE_O(idle));
	assign sel = {u_hss_if.xcvr_sel_bit1, u_hss_if.xcvr_sel_bit0};
	hss_assertions #(.STARTUP_CYCLES(SU))
	u_chk (.SYS_CLK_I(clk), .RSTN_I(rstn), .dtr(u_hss_if.dtr),
		.rts(u_hss_if.rts), .link_led_n(u_hss_if.link_led_n),
		.xcvr_sel_bit0(u_hss_if.xcvr_sel_bit0),
		.xcvr_sel_bit1(u_hss_if.xcvr_sel_bit1),
		.green_oe_mod(u_hss_if.green_oe_mod));

	// Clock, and a watchdog in case a step hangs
	initial
	begin
		forever #5 clk = ~clk;
	end
	initial
	begin
		#100us;
		error_cnt++;
		results();
	end
	// Counts connect pulses and unlit link samples
	always @(posedge clk)
	begin
		npulse += (conn_o === 1'b1);
		ndark += (u_hss_if.link_led_n === 1'b1);
	end

	// ==========================================
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic note(input bit ok, input string m);
		tests_run++;
		if (!ok)
		begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : note
	task automatic chk_bit(input logic got, input logic exp, input string m);
		note(got === exp, m);
	endtask : chk_bit
	task automatic chk_rst(input restore_e got, input restore_e exp);
		note(got === exp, "restore kind");
	endtask : chk_rst
	task automatic chk_cnt(input int got, input int exp, input string m);
		note(got == exp, m);
	endtask : chk_cnt
	task automatic results;
		$display("mismatches %0d, checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// Reset with straps set; connect held high must be ignored in startup
	task automatic boot(input logic r, input logic s);
		rstn = 1'b0;
		rreq = r;
		csw = s;
		creq = 1'b1;
		cyc(5);
		chk_bit(tx_en, 1'b0, "tx on in reset");
		chk_bit(rx_en_n, 1'b1, "rx on in reset");
		chk_bit(rvalid, 1'b0, "straps valid in reset");
		rstn = 1'b1;
		npulse = 0;
		cyc(10);
		chk_bit(idle, !r, "strap drive");
		cyc(SU);
		chk_bit(idle, 1'b1, "strap held past window");
		chk_cnt(npulse, 0, "connect in startup");
		chk_bit(running, 1'b1, "not running");
		chk_bit(ready, 1'b1, "host sees no ready");
		chk_bit(rvalid, 1'b1, "straps not sampled");
		creq = 1'b0;
		csw = 1'b0;
	endtask : boot

	// ==========================================
	// Main sequence
	initial
	begin
		boot(1'b0, 1'b0);
		chk_rst(rst_o, RESTORE_NONE);
		foreach (rows[i])
		begin
			{mode, flow, hrdy} = rows[i][6:3];
			cyc(10);
			note({u_hss_if.xcvr_sel_bit1, u_hss_if.xcvr_sel_bit0} === mode, "code");
			chk_bit(tx_en, rows[i][2], "tx enable");
			chk_bit(rx_en_n, rows[i][1], "rx enable");
			chk_bit(allowed, rows[i][0], "flow control");
		end
		// Flow control off ignores the host line; on, it pauses us
		hrdy = 1'b0;
		cyc(6);
		chk_bit(allowed, 1'b1, "cts used with flow off");
		flow = 1'b1;
		cyc(6);
		chk_bit(allowed, 1'b0, "cts ignored with flow on");
		hrdy = 1'b1;
		txp = 1'b0;
		cyc(6);
		chk_bit(allowed, 1'b0, "sending with nothing pending");
		txp = 1'b1;
		// No receive room: both ready lines drop
		rxs = 1'b0;
		cyc(6);
		chk_bit(running, 1'b0, "ready without room");
		chk_bit(mays, 1'b0, "host may send without room");
		rxs = 1'b1;
		cyc(6);
		chk_bit(mays, 1'b1, "host paused with room");
		// Green follows its source once running
		gon = 1'b0;
		cyc(4);
		chk_bit(u_hss_if.green_lvl, 1'b0, "green stuck high");
		gon = 1'b1;
		cyc(4);
		chk_bit(u_hss_if.green_lvl, 1'b1, "green stuck low");
		// Clock enable low freezes the select pins
		ce = 1'b0;
		mode = 2'h0;
		cyc(4);
		note(sel === 2'h3, "select moved while frozen");
		ce = 1'b1;
		cyc(4);
		note(sel === 2'h0, "select stuck after freeze");
		chk_bit(u_hss_if.red_strap_n, 1'b1, "aux strap pulled low");
		npulse = 0;
		creq = 1'b1;
		cyc(12);
		chk_cnt(npulse, 1, "ready request");
		csw = 1'b1;
		cyc(12);
		chk_cnt(npulse, 2, "switch request");
		lnk = 1'b1;
		cyc(40);
		chk_bit(u_hss_if.link_led_n, 1'b0, "link unlit");
		chk_bit(linked, 1'b1, "host sees no link");
		ndark = 0;
		trf = 1'b1;
		cyc(1);
		trf = 1'b0;
		cyc(12);
		note(ndark > 0, "no flash on traffic");
		chk_bit(linked, 1'b1, "flash not filtered");
		lnk = 1'b0;
		cyc(40);
		chk_bit(u_hss_if.link_led_n, 1'b1, "link still lit");
		chk_bit(linked, 1'b0, "host still linked");
		foreach (st[k])
		begin
			boot(st[k][1], st[k][0]);
			chk_rst(rst_o, ex[k]);
		end
		results();
	end
endmodule : host_serial_status_strap_interface_tb
